// ### pkg/tvs_cfg.svh
// Purpose: constants for the text video serializer
// Assumes: included by bare name
// Notes:   none
`ifndef TVS_CFG_SVH
`define TVS_CFG_SVH
`define TVS_BRT_CON_ADDR  20'hE8040
`define TVS_BRT_LSB       2
`define TVS_BRT_MSB       4
`define TVS_CON_LSB       5
`define TVS_CON_MSB       7
`define TVS_BIT_FIFTEEN   15
`define TVS_LOW_TEN_MASK  16'h03FF
`define TVS_ATTR_HALF_INTENSITY_ATTR   0
`define TVS_ATTR_RVS      1
`define TVS_ATTR_UNDL     2
`define TVS_ATTR_SECRET   3
`define TVS_CELL_STD      5'h0A
`define TVS_CELL_HIRES    5'h10
`define TVS_FIFO_DEPTH    8
`define TVS_LIT_LINE      16'hFFFF
`define TVS_STD_ALIGN     6
`define TVS_SEL_UNDL      3'h0
`define TVS_SEL_NORMAL    3'h2
`define TVS_SEL_REVERSE   3'h6
`endif

// ### pkg/tvs_pkg.sv
// Purpose: shared types for the text video serializer
// Assumes: nothing
// Notes:   attribute order follows the attribute bit positions
package tvs_pkg;
  typedef struct packed {
    logic [15:0] word;
    logic [4:0]  attr;
    logic        active_video_enable;
    logic        cursor;
  } tvs_cell_type;
  typedef struct packed {
    logic [4:0] attr;
    logic       cursor;
    logic       active_video_enable;
  } tvs_stage_type;
  typedef enum logic [0:0] {
    TVS_IDLE = 1'b0,
    TVS_RUN  = 1'b1
  } tvs_state_type;
endpackage

// ### logic/tvs_top.sv
// Purpose: character video serializer with attributes, sync and brightness port
// Assumes: strobes and timing inputs are asynchronous pins, synchronised here
// Notes:   dot clock is a pin sampled on core_clk_in; its detected rising edge acts as a one-cycle enable
`include "tvs_cfg.svh"

module tvs_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             ce_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic [WIDTH-1:0]      rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;
  always_comb begin
    push    = wr_valid_in && (cnt_r != (AW+1)'(DEPTH)) && ce_in;
    pop     = rd_ready_in && (cnt_r != '0) && ce_in;
    wp_nxt  = push ? wp_r + AW'(1) : wp_r;
    rp_nxt  = pop ? rp_r + AW'(1) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push) begin
      mem_r[wp_r] <= wr_data_in;
    end
  end
  assign wr_ready_out = cnt_r != (AW+1)'(DEPTH);
  assign rd_valid_out = cnt_r != '0;
  assign rd_data_out  = mem_r[rp_r];
endmodule // tvs_fifo

module tvs_top (
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        ce_in,
  input  wire logic        dot_clock_in,
  input  wire logic        word_capture_strobe_in,
  input  wire logic        shift_load_n_in,
  input  wire logic [15:0] memory_word_in,
  input  wire logic [4:0]  attribute_bits_in,
  input  wire logic        display_period_in,
  input  wire logic        cursor_display_in,
  input  wire logic        hires_select_bit_in,
  input  wire logic        hsync_in,
  input  wire logic        vsync_in,
  input  wire logic [19:0] port_addr_in,
  input  wire logic        port_wr_in,
  input  wire logic        port_rd_in,
  input  wire logic [7:0]  port_wdata_in,
  output logic [7:0]       port_rdata_out,
  output logic             video_out,
  output logic             low_intensity_out,
  output logic             hsync_out,
  output logic             vsync_out,
  output logic [2:0]       brightness_out,
  output logic [2:0]       contrast_out,
  output logic [4:0]       cell_width_out,
  output logic             fifo_full_out
);
  // Two-flop synchronisers for every strobe, timing and sync pin input; the port inputs are not synchronised
  localparam int NS = 8;
  logic [NS-1:0] s1_r, s2_r, s3_r, sin;
  assign sin = {vsync_in, hsync_in, hires_select_bit_in, cursor_display_in,
                display_period_in, shift_load_n_in, word_capture_strobe_in, dot_clock_in};
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else if (ce_in) begin
      s1_r <= sin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  logic [15:0] w1_r, w2_r;
  logic [4:0]  a1_r, a2_r;
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      w1_r <= '0;
      w2_r <= '0;
      a1_r <= '0;
      a2_r <= '0;
    end else if (ce_in) begin
      w1_r <= memory_word_in;
      w2_r <= w1_r;
      a1_r <= attribute_bits_in;
      a2_r <= a1_r;
    end
  end
  logic dot_rise, cap_rise, sl_rise, sl_low, active_video_enable_sync, cur_sync;
  assign dot_rise  = s2_r[0] && !s3_r[0];
  assign cap_rise  = s2_r[1] && !s3_r[1];
  assign sl_rise   = s2_r[2] && !s3_r[2];
  assign sl_low    = !s2_r[2];
  assign active_video_enable_sync = s2_r[3];
  assign cur_sync  = s2_r[4] && s2_r[3];

  // Captured cells wait in the FIFO until the shifter takes them
  tvs_pkg::tvs_cell_type cap_cell, hold_cell;
  logic                  hold_valid, hold_take, wr_ready;
  assign cap_cell.word   = w2_r;
  assign cap_cell.attr   = a2_r;
  assign cap_cell.active_video_enable   = active_video_enable_sync;
  assign cap_cell.cursor = cur_sync;
  tvs_fifo #(.WIDTH($bits(tvs_pkg::tvs_cell_type)), .DEPTH(`TVS_FIFO_DEPTH)) u_fifo (
    .core_clk_in  (core_clk_in),
    .sys_rst_in   (sys_rst_in),
    .ce_in        (ce_in),
    .wr_data_in   (cap_cell),
    .wr_valid_in  (cap_rise),
    .wr_ready_out (wr_ready),
    .rd_data_out  (hold_cell),
    .rd_valid_out (hold_valid),
    .rd_ready_in  (hold_take)
  );
  assign hold_take = sl_rise && hold_valid;

  // Shifter, attribute stages and output pixel path
  tvs_pkg::tvs_stage_type st1_r, st1_nxt, st2_r, st2_nxt;
  logic [15:0] cur_word_r, cur_word_nxt, shf_r, shf_nxt;
  logic [4:0]  dcnt_r, dcnt_nxt, width;
  logic        undl_inact_r, undl_inact_nxt, pix_r, pix_nxt, lowi_r, lowi_nxt;
  logic        full_r, full_nxt, hsync_r, vsync_r;
  logic        undl_sel_r, undl_sel_nxt, vid_r, vid_nxt;
  tvs_pkg::tvs_state_type st_r, st_nxt;
  logic [15:0] active_video_enable_word;
  logic        ser_bit, gated, sel_en;
  logic [2:0]  sel;
  logic [7:0]  din;
  always_comb begin
    width = s2_r[5] ? `TVS_CELL_HIRES : `TVS_CELL_STD;
    st1_nxt = st1_r;
    st2_nxt = st2_r;
    cur_word_nxt = cur_word_r;
    undl_inact_nxt = undl_inact_r;
    undl_sel_nxt = undl_sel_r;
    if (hold_take) begin
      st1_nxt.attr   = hold_cell.attr;
      st1_nxt.cursor = hold_cell.cursor;
      st1_nxt.active_video_enable   = hold_cell.active_video_enable;
      st2_nxt.attr   = st1_r.attr;
      st2_nxt.cursor = st1_r.cursor;
      st2_nxt.active_video_enable   = !st1_r.active_video_enable;
      cur_word_nxt   = hold_cell.word;
      undl_inact_nxt = !(hold_cell.attr[`TVS_ATTR_UNDL] &&
                         hold_cell.word[`TVS_BIT_FIFTEEN]);
      // Underline select follows the word into stage two with its attributes
      undl_sel_nxt   = undl_inact_r;
    end
    active_video_enable_word = undl_inact_r ? (cur_word_r & `TVS_LOW_TEN_MASK) : `TVS_LIT_LINE;
    shf_nxt  = shf_r;
    dcnt_nxt = dcnt_r;
    st_nxt   = st_r;
    if (dot_rise) begin
      if (sl_low) begin
        // Standard cells show bits nine down to zero, so align them to the top
        shf_nxt  = s2_r[5] ? active_video_enable_word : active_video_enable_word << `TVS_STD_ALIGN;
        dcnt_nxt = width;
        st_nxt   = tvs_pkg::TVS_RUN;
      end else begin
        shf_nxt  = {shf_r[14:0], 1'b0};
        dcnt_nxt = (dcnt_r != 5'h00) ? dcnt_r - 5'h01 : 5'h00;
        st_nxt   = (dcnt_r > 5'h01) ? tvs_pkg::TVS_RUN : tvs_pkg::TVS_IDLE;
      end
    end
    ser_bit = (st_r == tvs_pkg::TVS_RUN) && shf_r[`TVS_BIT_FIFTEEN];
    gated   = ser_bit && !st2_r.attr[`TVS_ATTR_SECRET];
    // Every select with cursor set is a constant high, whatever the pixel
    din                   = {4{1'b1, !gated}};
    din[`TVS_SEL_UNDL]    = gated;
    din[`TVS_SEL_NORMAL]  = gated;
    din[`TVS_SEL_REVERSE] = !gated;
    sel     = {st2_r.attr[`TVS_ATTR_RVS], undl_sel_r, st2_r.cursor};
    sel_en  = !st2_r.active_video_enable;
    pix_nxt = pix_r;
    lowi_nxt = lowi_r;
    if (dot_rise) begin
      pix_nxt  = sel_en ? din[sel] : 1'b0;
      lowi_nxt = st2_r.attr[`TVS_ATTR_HALF_INTENSITY_ATTR];
    end
    vid_nxt  = !pix_nxt;
    full_nxt = !wr_ready;
  end
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      st1_r        <= '0;
      st2_r        <= '{attr: 5'h00, cursor: 1'b0, active_video_enable: 1'b1};
      cur_word_r   <= '0;
      undl_inact_r <= 1'b1;
      undl_sel_r   <= 1'b1;
      vid_r        <= 1'b1;
      shf_r        <= '0;
      dcnt_r       <= '0;
      st_r         <= tvs_pkg::TVS_IDLE;
      pix_r        <= 1'b0;
      lowi_r       <= 1'b0;
      full_r       <= 1'b0;
      hsync_r      <= 1'b0;
      vsync_r      <= 1'b0;
    end else if (ce_in) begin
      st1_r        <= st1_nxt;
      st2_r        <= st2_nxt;
      cur_word_r   <= cur_word_nxt;
      undl_inact_r <= undl_inact_nxt;
      undl_sel_r   <= undl_sel_nxt;
      vid_r        <= vid_nxt;
      shf_r        <= shf_nxt;
      dcnt_r       <= dcnt_nxt;
      st_r         <= st_nxt;
      pix_r        <= pix_nxt;
      lowi_r       <= lowi_nxt;
      full_r       <= full_nxt;
      hsync_r      <= s2_r[6];
      vsync_r      <= s2_r[7];
    end
  end

  // Brightness and contrast port
  logic [7:0] port_r, port_nxt, rdata_r, rdata_nxt;
  logic       hit;
  logic [2:0] con_r, con_nxt;
  always_comb begin
    hit       = port_addr_in == `TVS_BRT_CON_ADDR;
    port_nxt  = (hit && port_wr_in) ? port_wdata_in : port_r;
    rdata_nxt = (hit && port_rd_in) ? port_r : 8'h00;
    // Contrast is inverted ahead of its flop so the pins come from a register
    con_nxt   = ~port_nxt[`TVS_CON_MSB:`TVS_CON_LSB];
  end
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      port_r  <= '0;
      rdata_r <= '0;
      con_r   <= '1;
    end else if (ce_in) begin
      port_r  <= port_nxt;
      rdata_r <= rdata_nxt;
      con_r   <= con_nxt;
    end
  end
  assign port_rdata_out    = rdata_r;
  assign video_out         = vid_r;
  assign low_intensity_out = lowi_r;
  assign hsync_out         = hsync_r;
  assign vsync_out         = vsync_r;
  assign brightness_out    = port_r[`TVS_BRT_MSB:`TVS_BRT_LSB];
  assign contrast_out      = con_r;
  assign cell_width_out    = dcnt_r;
  assign fifo_full_out     = full_r;

  property p_video_inv;
    @(posedge core_clk_in) disable iff (sys_rst_in) video_out == !pix_r;
  endproperty
  a_video_inv: assert property (p_video_inv) else $error("video not inverted");
  property p_contrast;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      contrast_out == ~port_r[`TVS_CON_MSB:`TVS_CON_LSB];
  endproperty
  a_contrast: assert property (p_contrast) else $error("contrast mapping wrong");
  sequence s_cursor_dot;
    dot_rise && !st2_r.active_video_enable && st2_r.cursor && ce_in;
  endsequence
  property p_cursor;
    @(posedge core_clk_in) disable iff (sys_rst_in) s_cursor_dot |=> !video_out;
  endproperty
  a_cursor: assert property (p_cursor) else $error("cursor not lit");
  property p_blank;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      (dot_rise && st2_r.active_video_enable && ce_in) |=> video_out;
  endproperty
  a_blank: assert property (p_blank) else $error("blanking failed");
  property p_load;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      (dot_rise && sl_low && ce_in) |=>
        (shf_r == ($past(s2_r[5]) ? $past(active_video_enable_word) : ($past(active_video_enable_word) << `TVS_STD_ALIGN)));
  endproperty
  a_load: assert property (p_load) else $error("shifter not loaded");
  property p_shift;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      (dot_rise && !sl_low && ce_in) |=> (shf_r[15:1] == $past(shf_r[14:0]));
  endproperty
  a_shift: assert property (p_shift) else $error("shifter did not shift");
  property p_stage2;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      (hold_take && ce_in) |=> (st2_r.active_video_enable == !$past(st1_r.active_video_enable));
  endproperty
  a_stage2: assert property (p_stage2) else $error("stage two active_video_enable not inverted");
  property p_secret;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      st2_r.attr[`TVS_ATTR_SECRET] |-> !gated;
  endproperty
  a_secret: assert property (p_secret) else $error("hidden pixel leaked");
  sequence s_shown_dot;
    dot_rise && !st2_r.active_video_enable && ce_in;
  endsequence
  property p_normal;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      (s_shown_dot ##0 (sel == `TVS_SEL_NORMAL)) |=> (video_out == !$past(gated));
  endproperty
  a_normal: assert property (p_normal) else $error("normal polarity wrong");
  property p_reverse;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      (s_shown_dot ##0 (sel == `TVS_SEL_REVERSE)) |=> (video_out == $past(gated));
  endproperty
  a_reverse: assert property (p_reverse) else $error("reverse polarity wrong");
  sequence s_lit_load;
    dot_rise && sl_low && !undl_inact_r && s2_r[5] && ce_in;
  endsequence
  property p_lit_line;
    @(posedge core_clk_in) disable iff (sys_rst_in) s_lit_load |=> (shf_r == `TVS_LIT_LINE);
  endproperty
  a_lit_line: assert property (p_lit_line) else $error("underline line not lit");
endmodule // tvs_top

// ### sim/tvs_monitor_model.sv
// Purpose: monitor-side model that samples the video pin once per dot
// Assumes: the video pin has settled well before the next dot rise
// Notes:   bits_out holds the last sixteen dots, oldest in the top bit
module tvs_monitor_model (
  input  wire logic   core_clk_in,
  input  wire logic   dot_clock_in,
  input  wire logic   video_in,
  output logic [15:0] bits_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic dot_q;
  initial begin
    dot_q = 1'b0;
    bits_out = 16'h0000;
  end
  always @(posedge core_clk_in) begin
    dot_q <= dot_clock_in;
    if (dot_clock_in && !dot_q) bits_out <= {bits_out[14:0], video_in};
  end
endmodule // tvs_monitor_model

// ### sim/test_text_video_serializer.sv
// Purpose: self-checking bench for the text video serializer
// Assumes: dot pin runs at one eighth of the core clock
// Notes:   serial checks accept any phase of a steady sixteen-dot pattern
`include "tvs_cfg.svh"
`define CHECK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
  errors++; $display("MISMATCH %s exp %h got %h", nm, exp, got); end end
module test_text_video_serializer;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0, rst = 1'b1, dot = 1'b0, cap = 1'b0, sld_n = 1'b1;
  logic [15:0] word = 16'h0000;
  logic [4:0]  attr = 5'h00;
  logic        active_video_enable = 1'b1, cur = 1'b0, hires = 1'b1, hs = 1'b0, vs = 1'b0;
  logic [19:0] addr = 20'h00000;
  logic        wr = 1'b0, rd = 1'b0;
  logic [7:0]  wdata = 8'h00, rdata;
  logic        video, half_intensity_attr, hs_o, vs_o, full;
  logic [2:0]  bright, contr;
  logic [4:0]  cw, cw_max = 5'h00;
  logic [15:0] seen;
  int          errors = 0, n_compared = 0;
  logic [15:0] wd [9] = '{16'h0F35, 16'h0F35, 16'h0F35, 16'h8F35, 16'h0F35,
                          16'h0F35, 16'h0F35, 16'h0F35, 16'h0F35};
  logic [4:0]  at [9] = '{5'h00, 5'h02, 5'h00, 5'h04, 5'h04, 5'h08, 5'h00, 5'h00, 5'h01};
  logic        dp [9] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  logic        cu [9] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  logic [15:0] ev [9] = '{16'hFCCA, 16'h0335, 16'h0000, 16'h0000, 16'hFCCA,
                          16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFCCA};
  logic        el [9] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  always #2.5 clk = ~clk;
  always @(posedge clk) if (cw > cw_max) cw_max <= cw;
  tvs_top tvs_top_inst (
    .core_clk_in(clk), .sys_rst_in(rst), .ce_in(1'b1), .dot_clock_in(dot),
    .word_capture_strobe_in(cap), .shift_load_n_in(sld_n), .memory_word_in(word),
    .attribute_bits_in(attr), .display_period_in(active_video_enable), .cursor_display_in(cur),
    .hires_select_bit_in(hires), .hsync_in(hs), .vsync_in(vs), .port_addr_in(addr),
    .port_wr_in(wr), .port_rd_in(rd), .port_wdata_in(wdata), .port_rdata_out(rdata),
    .video_out(video), .low_intensity_out(half_intensity_attr), .hsync_out(hs_o), .vsync_out(vs_o),
    .brightness_out(bright), .contrast_out(contr), .cell_width_out(cw),
    .fifo_full_out(full)
  );
  tvs_monitor_model tvs_monitor_model_inst (
    .core_clk_in(clk), .dot_clock_in(dot), .video_in(video), .bits_out(seen)
  );
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wrap_up();
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic port_write(input logic [19:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask
  task automatic port_read(input logic [19:0] a, output logic [7:0] d);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    d = rdata;
    cyc(1);
  endtask
  // One capture early in each cell, shift-load low across the last dot rise
  task automatic run_cells(input int ndots, input int ncells);
    for (int c = 0; c < ncells; c++) begin
      for (int d = 0; d < ndots; d++) begin
        dot = 1'b1;
        cyc(4);
        dot = 1'b0;
        if (d == 0) cap = 1'b1;
        if (d == 1) cap = 1'b0;
        if (d == ndots - 2) sld_n = 1'b0;
        if (d == ndots - 1) sld_n = 1'b1;
        cyc(4);
      end
    end
  endtask
  function automatic logic rot_match(input logic [15:0] s, input logic [15:0] e);
    logic [15:0] t;
    t = e;
    rot_match = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (s === t) rot_match = 1'b1;
      t = {t[14:0], t[15]};
    end
  endfunction
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    wrap_up();
  end
  initial begin
    logic [7:0] v, r;
    logic [2:0] k;
    cyc(12);
    rst = 1'b0;
    cyc(2);
    port_read(`TVS_BRT_CON_ADDR, r);
    `CHECK("port_rst", 8'h00, r)
    `CHECK("contrast_rst", 3'h7, contr)
    for (int i = 0; i < 8; i++) begin
      k = i[2:0];
      v = {k, k, 2'b10};
      port_write(`TVS_BRT_CON_ADDR, v);
      port_read(`TVS_BRT_CON_ADDR, r);
      `CHECK("port", v, r)
      `CHECK("brightness", k, bright)
      `CHECK("contrast", ~k, contr)
    end
    port_write(20'hE8041, 8'h5A);
    port_read(20'hE8041, r);
    `CHECK("unmapped", 8'h00, r)
    port_read(`TVS_BRT_CON_ADDR, r);
    `CHECK("port_kept", 8'hFE, r)
    for (int i = 0; i < 2; i++) begin
      hs = (i == 0);
      vs = (i != 0);
      cyc(6);
      `CHECK("hsync", hs, hs_o)
      `CHECK("vsync", vs, vs_o)
    end
    for (int i = 0; i < 9; i++) begin
      cap = 1'b1;
      cyc(4);
      cap = 1'b0;
      cyc(4);
    end
    `CHECK("fifo_full", 1'b1, full)
    for (int i = 0; i < 8; i++) begin
      sld_n = 1'b0;
      cyc(4);
      sld_n = 1'b1;
      cyc(4);
    end
    `CHECK("fifo_drained", 1'b0, full)
    for (int i = 0; i < 9; i++) begin
      word = wd[i];
      attr = at[i];
      active_video_enable = dp[i];
      cur = cu[i];
      cw_max = 5'h00;
      run_cells(16, 4);
      `CHECK("video", 1'b1, rot_match(seen, ev[i]))
      `CHECK("low_intensity", el[i], half_intensity_attr)
    end
    `CHECK("cell_hires", `TVS_CELL_HIRES, cw_max)
    hires = 1'b0;
    run_cells(10, 1);
    cw_max = 5'h00;
    run_cells(10, 2);
    `CHECK("cell_std", `TVS_CELL_STD, cw_max)
    wrap_up();
  end
endmodule // test_text_video_serializer
